/* include/ssm_map.svh */
// constants of the supervised serial memory slave
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH

`define SSM_CLK_PERIOD_NS   10
`define SSM_HOLD_TIMEOUT_MS 200
`define SSM_HOLD_CYCLES     ((`SSM_HOLD_TIMEOUT_MS * 1000000) / `SSM_CLK_PERIOD_NS)
`define SSM_GLITCH_NS       100
`define SSM_GLITCH_CYCLES   ((`SSM_GLITCH_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)
`define SSM_WRITE_CYCLE_MS  5
`define SSM_WRITE_CYCLES    ((`SSM_WRITE_CYCLE_MS * 1000000) / `SSM_CLK_PERIOD_NS)
`define SSM_TYPE_CODE       4'ha
`define SSM_CNT_W           32

`endif

/* include/ssm_pkg.sv */
// types of the supervised serial memory slave
package ssm_pkg;

    typedef enum logic [2:0] {
        SSM_IDLE  = 3'b000,
        SSM_ADDR  = 3'b001,
        SSM_AACK  = 3'b010,
        SSM_WDATA = 3'b011,
        SSM_WACK  = 3'b100,
        SSM_RDATA = 3'b101,
        SSM_RACK  = 3'b110,
        SSM_WAIT  = 3'b111
    } ssm_state_e;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } ssm_bus_ev_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ssm_byte_s;

endpackage : ssm_pkg

/* rtl/ssm_sync.sv */
// three-stage synchroniser with agreement on the last two stages
`timescale 1ns/1ps

module ssm_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    input  wire logic init_i,
    output logic      level_o,
    output logic      fall_o,
    output logic      rise_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_ff <= init_i;
            s2_ff <= init_i;
            s3_ff <= init_i;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a change counts only once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_ff <= init_i;
        end else if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end

    assign level_o = level_ff;
    assign fall_o  = level_ff & (s2_ff == s3_ff) & ~s3_ff;
    assign rise_o  = ~level_ff & (s2_ff == s3_ff) & s3_ff;
endmodule : ssm_sync

/* rtl/ssm_top.sv */
// supply supervisor and serial memory bus front end
`timescale 1ns/1ps
`include "ssm_map.svh"

module ssm_top #(
    parameter int unsigned HOLD_CYCLES   = `SSM_HOLD_CYCLES,
    parameter int unsigned WRITE_CYCLES  = `SSM_WRITE_CYCLES,
    parameter int unsigned GLITCH_CYCLES = `SSM_GLITCH_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       supply_ok_i,
    input  wire logic       pushbutton_input_n_i,
    input  wire logic       write_protect_i,
    input  wire logic       reset_pin_i,
    output logic            reset_pin_o,
    output logic            reset_pin_oe_o,
    output logic            reset_hi_o,
    output logic            reset_hi_oe_o,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [7:0] rd_data_i,
    output logic            rd_req_o,
    output logic            wr_valid_o,
    output logic [7:0]      wr_data_o,
    output logic            write_busy_o
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic sup_lvl, mr_lvl, rp_lvl, rp_fall, scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;

    ssm_sync u_sup (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(supply_ok_i),
                    .init_i(1'b0), .level_o(sup_lvl), .fall_o(), .rise_o());
    ssm_sync u_mr  (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(pushbutton_input_n_i),
                    .init_i(1'b1), .level_o(mr_lvl), .fall_o(), .rise_o());
    ssm_sync u_rp  (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(reset_pin_i),
                    .init_i(1'b1), .level_o(rp_lvl), .fall_o(rp_fall), .rise_o());
    ssm_sync u_scl (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(scl_i),
                    .init_i(1'b1), .level_o(scl_lvl), .fall_o(scl_fall),
                    .rise_o(scl_rise));
    ssm_sync u_sda (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(sda_i),
                    .init_i(1'b1), .level_o(sda_lvl), .fall_o(sda_fall),
                    .rise_o(sda_rise));

    // ----------------------------------------------------------------
    // pushbutton glitch filter
    // ----------------------------------------------------------------
    logic [7:0] mr_cnt_ff;
    logic       mr_low_ff;

    // low must persist past the glitch window before it counts
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mr_cnt_ff <= 8'h00;
            mr_low_ff <= 1'b0;
        end else if (mr_lvl) begin
            mr_cnt_ff <= 8'h00;
            mr_low_ff <= 1'b0;
        end else if (mr_cnt_ff >= 8'(GLITCH_CYCLES)) begin
            mr_low_ff <= 1'b1;
        end else begin
            mr_cnt_ff <= mr_cnt_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // hold timeout
    // ----------------------------------------------------------------
    logic [`SSM_CNT_W-1:0] hold_cnt_ff;
    logic                  in_reset;
    logic                  trigger;

    // own driving of the pin must not retrigger, so only external falls count
    // the loaded counter marks our own drive; the pin fall trails it by the synchroniser
    assign trigger = ~sup_lvl | mr_low_ff | (rp_fall & (hold_cnt_ff == '0));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hold_cnt_ff <= `SSM_CNT_W'(HOLD_CYCLES);
        end else if (trigger) begin
            hold_cnt_ff <= `SSM_CNT_W'(HOLD_CYCLES);
        end else if (hold_cnt_ff != '0) begin
            hold_cnt_ff <= hold_cnt_ff - `SSM_CNT_W'(1);
        end
    end

    assign in_reset       = trigger | (hold_cnt_ff != '0);
    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_o = in_reset;
    assign reset_hi_o     = 1'b1;
    assign reset_hi_oe_o  = in_reset;

    // ----------------------------------------------------------------
    // bus conditions
    // ----------------------------------------------------------------
    logic start_ev, stop_ev;
    assign start_ev = sda_fall & scl_lvl;
    assign stop_ev  = sda_rise & scl_lvl;

    // ----------------------------------------------------------------
    // internal write cycle timer
    // ----------------------------------------------------------------
    logic [`SSM_CNT_W-1:0] wcyc_cnt_ff;
    logic                  wr_pending_ff;
    logic                  busy;

    assign busy         = wcyc_cnt_ff != '0;
    assign write_busy_o = busy;

    // a running cycle always completes; a new one never starts in reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wcyc_cnt_ff <= '0;
        end else if (busy) begin
            wcyc_cnt_ff <= wcyc_cnt_ff - `SSM_CNT_W'(1);
        end else if (stop_ev && wr_pending_ff && !in_reset) begin
            wcyc_cnt_ff <= `SSM_CNT_W'(WRITE_CYCLES);
        end
    end

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    ssm_pkg::ssm_state_e state_ff;
    logic [3:0]          bit_ff;
    logic [7:0]          sh_ff;
    logic                sda_oe_ff;
    logic                rd_req_ff;
    logic                wr_valid_ff;
    logic [7:0]          wr_data_ff;

    function automatic logic addr_match(input logic [7:0] b);
        addr_match = b[7:4] == `SSM_TYPE_CODE;
    endfunction : addr_match

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff      <= ssm_pkg::SSM_IDLE;
            bit_ff        <= 4'h0;
            sh_ff         <= 8'h00;
            sda_oe_ff     <= 1'b0;
            rd_req_ff     <= 1'b0;
            wr_valid_ff   <= 1'b0;
            wr_data_ff    <= 8'h00;
            wr_pending_ff <= 1'b0;
        end else begin
            rd_req_ff   <= 1'b0;
            wr_valid_ff <= 1'b0;
            if (in_reset) begin
                state_ff      <= ssm_pkg::SSM_IDLE;
                sda_oe_ff     <= 1'b0;
                wr_pending_ff <= 1'b0;
            end else if (stop_ev) begin
                state_ff      <= ssm_pkg::SSM_IDLE;
                sda_oe_ff     <= 1'b0;
                wr_pending_ff <= 1'b0;
            end else if (start_ev) begin
                state_ff  <= ssm_pkg::SSM_ADDR;
                bit_ff    <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ssm_pkg::SSM_ADDR, ssm_pkg::SSM_WDATA: begin
                        if (scl_rise) begin
                            sh_ff  <= {sh_ff[6:0], sda_lvl};
                            bit_ff <= bit_ff + 4'h1;
                        end else if (scl_fall && bit_ff == 4'h8) begin
                            bit_ff <= 4'h0;
                            if (state_ff == ssm_pkg::SSM_ADDR) begin
                                if (addr_match(sh_ff) && !busy) begin
                                    sda_oe_ff <= 1'b1;
                                    state_ff  <= ssm_pkg::SSM_AACK;
                                    rd_req_ff <= sh_ff[0];
                                end else begin
                                    state_ff <= ssm_pkg::SSM_WAIT;
                                end
                            end else if (!write_protect_i) begin
                                sda_oe_ff     <= 1'b1;
                                wr_valid_ff   <= 1'b1;
                                wr_data_ff    <= sh_ff;
                                wr_pending_ff <= 1'b1;
                                state_ff      <= ssm_pkg::SSM_WACK;
                            end else begin
                                state_ff <= ssm_pkg::SSM_WAIT;
                            end
                        end
                    end
                    ssm_pkg::SSM_AACK: begin
                        if (scl_fall) begin
                            if (sh_ff[0]) begin
                                sh_ff     <= rd_data_i;
                                sda_oe_ff <= ~rd_data_i[7];
                                state_ff  <= ssm_pkg::SSM_RDATA;
                                bit_ff    <= 4'h1;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                state_ff  <= ssm_pkg::SSM_WDATA;
                            end
                        end
                    end
                    ssm_pkg::SSM_WACK: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            state_ff  <= ssm_pkg::SSM_WDATA;
                        end
                    end
                    ssm_pkg::SSM_RDATA: begin
                        if (scl_fall) begin
                            if (bit_ff == 4'h8) begin
                                sda_oe_ff <= 1'b0;
                                state_ff  <= ssm_pkg::SSM_RACK;
                            end else begin
                                sda_oe_ff <= ~sh_ff[3'(7 - bit_ff)];
                                bit_ff    <= bit_ff + 4'h1;
                            end
                        end
                    end
                    ssm_pkg::SSM_RACK: begin
                        if (scl_rise) begin
                            if (!sda_lvl) begin
                                rd_req_ff <= 1'b1;
                                state_ff  <= ssm_pkg::SSM_AACK;
                                sh_ff[0]  <= 1'b1;
                            end else begin
                                state_ff <= ssm_pkg::SSM_WAIT;
                            end
                        end
                    end
                    ssm_pkg::SSM_WAIT, ssm_pkg::SSM_IDLE: begin
                        sda_oe_ff <= 1'b0;
                    end
                    default: begin
                        state_ff <= ssm_pkg::SSM_IDLE;
                    end
                endcase
            end
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_o   = sda_oe_ff;
    assign rd_req_o   = rd_req_ff;
    assign wr_valid_o = wr_valid_ff;
    assign wr_data_o  = wr_data_ff;
endmodule : ssm_top

/* verif/ssm_checker.sv */
// port assertions of the supervised serial memory slave
`timescale 1ns/1ps
module ssm_checker #(
    parameter int unsigned HOLD_CYCLES   = 200,
    parameter int unsigned WRITE_CYCLES  = 300,
    parameter int unsigned GLITCH_CYCLES = 10
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_ok_i,
    input wire logic pushbutton_input_n_i,
    input wire logic write_protect_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o,
    input wire logic reset_hi_o,
    input wire logic reset_hi_oe_o,
    input wire logic sda_oe_o,
    input wire logic rd_req_o,
    input wire logic wr_valid_o,
    input wire logic write_busy_o
);
    int unsigned hi_cnt_ff, bz_cnt_ff, pb_cnt_ff;
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // --------------------------------------------------------------
    // run lengths; a sampled count trails the level by one cycle
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) hi_cnt_ff <= (rst_n_i && reset_pin_oe_o) ? hi_cnt_ff + 1 : 0;
    always_ff @(posedge clk_i) bz_cnt_ff <= (rst_n_i && write_busy_o) ? bz_cnt_ff + 1 : 0;
    always_ff @(posedge clk_i) pb_cnt_ff <= (rst_n_i && !pushbutton_input_n_i) ? pb_cnt_ff + 1 : 0;
    property p_outs; reset_hi_oe_o == reset_pin_oe_o && !reset_pin_o && reset_hi_o; endproperty
    property p_sup; !supply_ok_i [*3] |-> ##[0:6] reset_pin_oe_o; endproperty
    property p_hold; $fell(reset_pin_oe_o) |-> $past(hi_cnt_ff) + 2 >= HOLD_CYCLES; endproperty
    property p_pb; pb_cnt_ff >= GLITCH_CYCLES + 8 |-> reset_pin_oe_o; endproperty
    property p_abort; reset_pin_oe_o [*6] |-> !sda_oe_o; endproperty
    property p_bzlen;
        $fell(write_busy_o) |-> $past(bz_cnt_ff) + 2 >= WRITE_CYCLES
                                && $past(bz_cnt_ff) <= WRITE_CYCLES + 1;
    endproperty
    property p_bzrst; $rose(write_busy_o) |-> !reset_pin_oe_o; endproperty
    property p_wp; $rose(write_busy_o) |-> !write_protect_i; endproperty
    property p_quiet; write_busy_o |-> !sda_oe_o; endproperty
    property p_wrpl; wr_valid_o |=> !wr_valid_o; endproperty
    a_outs: assert property (p_outs) else $error("reset outputs disagree");
    a_sup: assert property (p_sup) else $error("low supply without reset");
    a_hold: assert property (p_hold) else $error("reset released early");
    a_pb: assert property (p_pb) else $error("pushbutton low without reset");
    a_abort: assert property (p_abort) else $error("sda driven in reset");
    a_bzlen: assert property (p_bzlen) else $error("write cycle length wrong");
    a_bzrst: assert property (p_bzrst) else $error("write cycle begun in reset");
    a_wp: assert property (p_wp) else $error("write cycle while protected");
    a_quiet: assert property (p_quiet) else $error("sda driven while busy");
    a_wrpl: assert property (p_wrpl) else $error("write strobe too long");
    c_wr: cover property ($rose(write_busy_o));
    c_pb: cover property (pb_cnt_ff == GLITCH_CYCLES + 8);
    c_rd: cover property (rd_req_o);
endmodule : ssm_checker

bind ssm_top ssm_checker #(
    .HOLD_CYCLES(HOLD_CYCLES), .WRITE_CYCLES(WRITE_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES)
) u_ssm_checker (
    .clk_i, .rst_n_i, .supply_ok_i, .pushbutton_input_n_i, .write_protect_i, .reset_pin_o,
    .reset_pin_oe_o, .reset_hi_o, .reset_hi_oe_o, .sda_oe_o, .rd_req_o, .wr_valid_o,
    .write_busy_o
);

/* verif/ssm_master.sv */
// bus master model: scl idles high outside frames, sda released is pulled up
`timescale 1ns/1ps
module ssm_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk
    // ------------------------------------------------------------------
    // one bit of 16 cycles; sda moves a cycle after scl falls
    // ------------------------------------------------------------------
    task automatic bitx(input logic b, output logic r);
        tk(1);
        sda_o <= b;
        tk(7);
        scl_o <= 1'b1;
        tk(4);
        r = sda_i;
        tk(4);
        scl_o <= 1'b0;
    endtask : bitx
    task automatic start();
        tk(1);
        sda_o <= 1'b1;
        tk(7);
        scl_o <= 1'b1;
        tk(8);
        sda_o <= 1'b0;
        tk(8);
        scl_o <= 1'b0;
    endtask : start
    task automatic stop();
        tk(1);
        sda_o <= 1'b0;
        tk(7);
        scl_o <= 1'b1;
        tk(8);
        sda_o <= 1'b1;
        tk(8);
    endtask : stop
    task automatic xfer(input logic [7:0] tx, input logic ain,
                        output logic [7:0] rx, output logic aout);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(ain, aout);
    endtask : xfer
endmodule : ssm_master

/* verif/tb.sv */
// self-checking bench of the supervised serial memory slave
`timescale 1ns/1ps
module tb;
    localparam int unsigned HOLD = 200;
    localparam int unsigned WRC  = 300;
    localparam int unsigned GLC  = 10;
    logic       clk_i = 1'b0, rst_n_i = 1'b0, supply_ok_i = 1'b0;
    logic       pushbutton_input_n_i = 1'b1, write_protect_i = 1'b0, ext_n = 1'b1;
    logic [7:0] rd_data_i = 8'h00, wr_data_o, rx, a, d0, d1;
    logic       reset_pin_o, reset_pin_oe_o, reset_hi_o, reset_hi_oe_o, scl_i, sda_m;
    logic       sda_o, sda_oe_o, rd_req_o, wr_valid_o, write_busy_o, ak, q;
    wire        sda_i = sda_m & ~sda_oe_o;
    wire        reset_pin_i = ext_n & ~reset_pin_oe_o;
    int         num_errors = 0, tests_run = 0, seed = 46, r, rd_seen = 0;
    logic [7:0] exp_wr[$];
    ssm_top #(.HOLD_CYCLES(HOLD), .WRITE_CYCLES(WRC), .GLITCH_CYCLES(GLC)) u_ssm_top (
        .clk_i, .rst_n_i, .supply_ok_i, .pushbutton_input_n_i, .write_protect_i,
        .reset_pin_i, .reset_pin_o, .reset_pin_oe_o, .reset_hi_o, .reset_hi_oe_o,
        .scl_i, .sda_i, .sda_o, .sda_oe_o, .rd_data_i, .rd_req_o, .wr_valid_o,
        .wr_data_o, .write_busy_o);
    ssm_master u_master (.clk_i, .sda_i, .scl_o(scl_i), .sda_o(sda_m));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic sb(input logic [7:0] tx, input logic ain, input logic [7:0] erx,
                      input logic ea);
        u_master.xfer(tx, ain, rx, ak);
        chk(rx, erx);
        chk({7'h0, ak}, {7'h0, ea});
    endtask : sb
    task automatic wb(input logic [7:0] d, input logic ea);
        if (!ea) exp_wr.push_back(d);
        sb(d, 1'b1, d, ea);
    endtask : wb
    task automatic at(input int n, input logic e);
        repeat (n) @(negedge clk_i);
        chk({7'h0, reset_pin_oe_o}, {7'h0, e});
    endtask : at
    task automatic wait_rel(input int n);
        repeat (n) if (reset_pin_oe_o !== 1'b0) @(negedge clk_i);
        chk({7'h0, reset_pin_oe_o}, 8'h00);
    endtask : wait_rel
    // every accepted byte must match the oldest note
    always @(negedge clk_i)
        if (wr_valid_o === 1'b1)
            chk(wr_data_o, exp_wr.size() != 0 ? exp_wr.pop_front() : ~wr_data_o);
    // read byte requests: one per read address, one per master acknowledge
    always @(negedge clk_i)
        if (rd_req_o === 1'b1)
            rd_seen++;
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        at(20, 1'b1);
        @(posedge clk_i) supply_ok_i <= 1'b1;
        wait_rel(HOLD + 40);
        // ------------------------------------------------------------
        // write, then polls: refused while busy, accepted after
        // ------------------------------------------------------------
        r = $random(seed);
        a = {4'ha, r[2:0], 1'b0};
        u_master.start();
        sb(a, 1'b1, a, 1'b0);
        wb(r[15:8], 1'b0);
        wb(r[23:16], 1'b0);
        u_master.stop();
        @(negedge clk_i);
        chk({7'h0, write_busy_o}, 8'h01);
        u_master.start();
        sb(8'ha0, 1'b1, 8'ha0, 1'b1);
        u_master.stop();
        repeat (WRC) @(posedge clk_i);
        u_master.start();
        sb(a, 1'b1, a, 1'b0);
        u_master.stop();
        // foreign type code, then a byte with no start before it
        r = $random(seed);
        a = {(r[7:4] == 4'ha) ? 4'h5 : r[7:4], r[3:0]};
        u_master.start();
        sb(a, 1'b1, a, 1'b1);
        u_master.stop();
        sb(8'ha0, 1'b1, 8'ha0, 1'b1);
        // random read over a repeated start
        r = $random(seed);
        d0 = r[7:0];
        d1 = r[15:8];
        u_master.start();
        sb(8'ha0, 1'b1, 8'ha0, 1'b0);
        wb(r[23:16], 1'b0);
        rd_data_i <= d0;
        u_master.start();
        sb(8'ha1, 1'b1, 8'ha1, 1'b0);
        repeat (8) @(posedge clk_i);
        rd_data_i <= d1;
        sb(8'hff, 1'b0, d0, 1'b0);
        sb(8'hff, 1'b1, d1, 1'b1);
        sb(8'hff, 1'b1, 8'hff, 1'b1);
        u_master.stop();
        chk(8'(rd_seen), 8'h02);
        repeat (WRC) @(posedge clk_i);
        write_protect_i <= 1'b1;
        u_master.start();
        sb(8'ha0, 1'b1, 8'ha0, 1'b0);
        wb(8'h3c, 1'b1);
        wb(8'hc3, 1'b1);
        u_master.stop();
        @(negedge clk_i);
        chk({7'h0, write_busy_o}, 8'h00);
        @(posedge clk_i) write_protect_i <= 1'b0;
        // pushbutton reset in mid write: aborted, no write cycle
        u_master.start();
        sb(8'ha0, 1'b1, 8'ha0, 1'b0);
        wb(8'h11, 1'b0);
        pushbutton_input_n_i <= 1'b0;
        at(30, 1'b1);
        sb(8'h22, 1'b1, 8'h22, 1'b1);
        u_master.stop();
        @(negedge clk_i);
        chk({7'h0, write_busy_o}, 8'h00);
        @(posedge clk_i) pushbutton_input_n_i <= 1'b1;
        at(HOLD - 20, 1'b1);
        wait_rel(60);
        // supply loss while a write cycle runs: cycle goes on
        u_master.start();
        sb(8'ha0, 1'b1, 8'ha0, 1'b0);
        wb(8'h77, 1'b0);
        u_master.stop();
        @(posedge clk_i) supply_ok_i <= 1'b0;
        at(10, 1'b1);
        chk({7'h0, write_busy_o}, 8'h01);
        u_master.start();
        sb(8'ha0, 1'b1, 8'ha0, 1'b1);
        u_master.stop();
        @(posedge clk_i) supply_ok_i <= 1'b1;
        wait_rel(HOLD + 40);
        // short pushbutton glitch, then a short external pin pulse
        @(posedge clk_i) pushbutton_input_n_i <= 1'b0;
        repeat (GLC / 2) @(posedge clk_i);
        pushbutton_input_n_i <= 1'b1;
        q = 1'b0;
        repeat (30) begin
            @(negedge clk_i);
            q = q | reset_pin_oe_o;
        end
        chk({7'h0, q}, 8'h00);
        @(posedge clk_i) ext_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        ext_n <= 1'b1;
        at(10, 1'b1);
        at(HOLD - 20, 1'b1);
        wait_rel(60);
        chk(8'(exp_wr.size()), 8'h00);
        give_verdict();
    end
endmodule : tb
